// ===== core/dhp_chan_pins.sv
// per-channel ready, interrupt and line status pin logic
`timescale 1ns/1ps
`default_nettype none
module dhp_chan_pins #(
    parameter int FIFO_DEPTH = 64,
    parameter int CNT_W = 7
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_fifo_en,
    input wire logic i_dma_en,
    input wire logic i_auto_rs485,
    input wire logic [CNT_W-1:0] i_rx_count,
    input wire logic [CNT_W-1:0] i_tx_count,
    input wire logic [CNT_W-1:0] i_rx_trigger,
    input wire logic [CNT_W-1:0] i_tx_trigger,
    input wire logic i_rx_timeout,
    input wire logic i_lsr_error,
    input wire logic i_tx_shift_empty,
    output logic o_rx_ready_n,
    output logic o_tx_ready_n,
    output logic o_irq,
    output logic o_thr_room,
    output logic o_tx_empty
);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

    logic rx_rdy_q, rx_rdy_d, tx_rdy_q, tx_rdy_d;
    logic tx_term_q, tx_term_d, rx_term_q, rx_term_d;
    logic room_q, room_d, empty_q, empty_d;
    logic irq_q, irq_d;
    logic rx_none, tx_none;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rx_none = (i_rx_count == CNT_ZERO);
        tx_none = (i_tx_count == CNT_ZERO);
        rx_rdy_d = rx_rdy_q;
        tx_rdy_d = tx_rdy_q;
        if (i_fifo_en && i_dma_en) begin
            // block mode: edges only, level held in between
            if (rx_none || i_lsr_error) begin
                rx_rdy_d = 1'b1;
            end else if (i_rx_count >= i_rx_trigger || i_rx_timeout) begin
                rx_rdy_d = 1'b0;
            end
            if (i_tx_count == CNT_FULL) begin
                tx_rdy_d = 1'b1;
            end else if (i_tx_count < i_tx_trigger) begin
                tx_rdy_d = 1'b0;
            end
        end else begin
            // holding register and single-character fifo read the same way
            rx_rdy_d = rx_none;
            tx_rdy_d = !tx_none;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        tx_term_d = tx_term_q;
        rx_term_d = 1'b1;
        if (!i_fifo_en) begin
            if (!tx_none) begin
                tx_term_d = 1'b0;
            end else begin
                tx_term_d = i_auto_rs485 ? i_tx_shift_empty : 1'b1;
            end
        end else begin
            if (i_tx_count > i_tx_trigger) begin
                tx_term_d = 1'b0;
            end else if (i_auto_rs485) begin
                if (i_tx_count < i_tx_trigger || i_tx_shift_empty) begin
                    tx_term_d = 1'b1;
                end
            end else if (i_tx_count < i_tx_trigger || tx_none) begin
                tx_term_d = 1'b1;
            end
            // exactly at the trigger level the last state is kept
            rx_term_d = rx_term_q;
            if (i_rx_count < i_rx_trigger) begin
                rx_term_d = 1'b0;
            end else if (i_rx_count > i_rx_trigger) begin
                rx_term_d = 1'b1;
            end
        end
        room_d = i_fifo_en ? (i_tx_count < CNT_FULL) : tx_none;
        empty_d = tx_none && i_tx_shift_empty;
        // either source pulls the shared pin low
        irq_d = tx_term_d & rx_term_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rx_rdy_q <= 1'b1;
            tx_rdy_q <= 1'b0;
            tx_term_q <= 1'b1;
            rx_term_q <= 1'b1;
            room_q <= 1'b1;
            empty_q <= 1'b1;
            irq_q <= 1'b1;
        end else begin
            rx_rdy_q <= rx_rdy_d;
            tx_rdy_q <= tx_rdy_d;
            tx_term_q <= tx_term_d;
            rx_term_q <= rx_term_d;
            room_q <= room_d;
            empty_q <= empty_d;
            irq_q <= irq_d;
        end
    end

    assign o_rx_ready_n = rx_rdy_q;
    assign o_tx_ready_n = tx_rdy_q;
    // registered so the pin never glitches between the two terms
    assign o_irq = irq_q;
    assign o_thr_room = room_q;
    assign o_tx_empty = empty_q;
endmodule // dhp_chan_pins
`default_nettype wire

// ===== core/dhp_host_port.sv
// host bus port of a dual uart: channel select, reset and status pins
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port
    import dhp_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter int CNT_W = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bus_style,
    input wire logic i_reset_pin,
    input wire logic i_chan_a_select_n,
    input wire logic i_chan_b_select_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_channel_addr_bit,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic [DATA_W-1:0] i_rd_data_a,
    input wire logic [DATA_W-1:0] i_rd_data_b,
    input wire logic [NUM_CH-1:0] i_auto_rs485,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_rx_count,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_tx_count,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_rx_trigger,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_tx_trigger,
    input wire logic [NUM_CH-1:0] i_rx_timeout,
    input wire logic [NUM_CH-1:0] i_lsr_error,
    input wire logic [NUM_CH-1:0] i_tx_shift_empty,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic [ADDR_W-1:0] o_reg_addr,
    output logic [DATA_W-1:0] o_wr_data,
    output logic [NUM_CH-1:0] o_wr_pulse,
    output logic [NUM_CH-1:0] o_rd_pulse,
    output logic o_chan_reset,
    output logic [NUM_CH-1:0] o_fifo_enable,
    output logic [NUM_CH-1:0] o_dma_mode,
    output logic [NUM_CH-1:0] o_rx_ready_n,
    output logic [NUM_CH-1:0] o_tx_ready_n,
    output logic o_irq_chan_a,
    output logic o_irq_chan_b,
    output logic [NUM_CH-1:0] o_lsr_thr_room,
    output logic [NUM_CH-1:0] o_lsr_tx_empty
);
    initial begin
        if (FIFO_DEPTH < 2 || FIFO_DEPTH >= (1 << CNT_W)) begin
            $error("dhp_host_port: FIFO_DEPTH does not fit CNT_W");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: every host pin is asynchronous to i_clock
    localparam int SYNC_W = 7 + ADDR_W + DATA_W;
    // idle pattern: strobes and selects high, dual style, reset pin low
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 18'h3E000;

    logic [SYNC_W-1:0] meta_q, meta_d, sync_q, sync_d;
    logic s_style, s_reset_pin, s_csa_n, s_csb_n, s_rd_n, s_wr_n, s_abit;
    logic [ADDR_W-1:0] s_addr;
    logic [DATA_W-1:0] s_data;

    always_comb begin
        meta_d = {i_bus_style, i_chan_a_select_n, i_chan_b_select_n, i_read_strobe_n,
                  i_write_strobe_n, i_reset_pin, i_channel_addr_bit, i_addr, i_data};
        sync_d = meta_q;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign {s_style, s_csa_n, s_csb_n, s_rd_n, s_wr_n, s_reset_pin, s_abit, s_addr, s_data}
        = sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // reset pin qualification; a glitch shorter than the minimum is ignored
    logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic chan_rst_q, chan_rst_d;
    logic pin_rst_active;
    logic dev_rst_n;

    always_comb begin
        // dual style uses an active high pin, single style active low
        pin_rst_active = (dhp_style_type'(s_style) == STYLE_DUAL) ? s_reset_pin
                                                                : !s_reset_pin;
        rst_cnt_d = RST_CNT_ZERO;
        if (pin_rst_active) begin
            rst_cnt_d = (rst_cnt_q == RST_CNT_TARGET) ? rst_cnt_q : rst_cnt_q + RST_CNT_ONE;
        end
        // third consecutive active sample asserts: pulse strictly longer than the minimum
        chan_rst_d = pin_rst_active && (rst_cnt_d == RST_CNT_TARGET);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rst_cnt_q <= RST_CNT_ZERO;
            chan_rst_q <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            chan_rst_q <= chan_rst_d;
        end
    end

    assign dev_rst_n = i_rst_n && !chan_rst_q;

    ////////////////////////////////////////////////////////////////////////////////
    // channel decode and asynchronous bus cycle tracking
    dhp_bus_state_type state_q, state_d;
    logic [NUM_CH-1:0] sel_now, sel_q, sel_d;
    logic [NUM_CH-1:0] wr_pulse_q, wr_pulse_d, rd_pulse_q, rd_pulse_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic oe_q, oe_d;
    logic one_sel;

    always_comb begin
        if (dhp_style_type'(s_style) == STYLE_DUAL) begin
            sel_now = {!s_csb_n, !s_csa_n};
        end else if (!s_csa_n) begin
            sel_now = s_abit ? SEL_B : SEL_A;
        end else begin
            sel_now = SEL_NONE;
        end
    end

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        oe_d = 1'b0;
        wr_pulse_d = SEL_NONE;
        rd_pulse_d = SEL_NONE;
        one_sel = (sel_q == SEL_A) || (sel_q == SEL_B);
        unique case (state_q)
            BUS_IDLE: begin
                // a cycle exists only while select and a strobe are both low
                if (sel_now != SEL_NONE && !s_rd_n) begin
                    state_d = BUS_READ;
                    sel_d = sel_now;
                    addr_d = s_addr;
                    // a read of both channels at once is refused
                    if (sel_now == SEL_A || sel_now == SEL_B) begin
                        rd_pulse_d = sel_now;
                    end
                end else if (sel_now != SEL_NONE && !s_wr_n) begin
                    state_d = BUS_WRITE;
                    sel_d = sel_now;
                    addr_d = s_addr;
                    wdata_d = s_data;
                end
            end
            BUS_READ: begin
                rdata_d = (sel_q == SEL_B) ? i_rd_data_b : i_rd_data_a;
                if (s_rd_n || sel_now != sel_q) begin
                    state_d = BUS_IDLE;
                end else begin
                    oe_d = one_sel;
                end
            end
            BUS_WRITE: begin
                // data latched while the strobe is low, committed at its rising edge
                if (s_wr_n) begin
                    wr_pulse_d = sel_q;
                    state_d = BUS_IDLE;
                end else begin
                    addr_d = s_addr;
                    wdata_d = s_data;
                    if (sel_now == SEL_NONE) begin
                        state_d = BUS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!dev_rst_n) begin
            state_q <= BUS_IDLE;
            sel_q <= SEL_NONE;
            addr_q <= ADDR_ZERO;
            wdata_q <= DATA_ZERO;
            rdata_q <= DATA_ZERO;
            oe_q <= 1'b0;
            wr_pulse_q <= SEL_NONE;
            rd_pulse_q <= SEL_NONE;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            oe_q <= oe_d;
            wr_pulse_q <= wr_pulse_d;
            rd_pulse_q <= rd_pulse_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel fifo control bits and status pins
    logic [NUM_CH-1:0] fifo_en_q, fifo_en_d, dma_q, dma_d;
    logic [NUM_CH-1:0] irq_ch;

    always_comb begin
        fifo_en_d = fifo_en_q;
        dma_d = dma_q;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (wr_pulse_d[ch] && addr_q == FCR_ADDR) begin
                fifo_en_d[ch] = wdata_q[FCR_FIFO_EN_BIT];
                dma_d[ch] = wdata_q[FCR_DMA_BIT];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!dev_rst_n) begin
            fifo_en_q <= {NUM_CH{FCR_FIFO_EN_RST}};
            dma_q <= {NUM_CH{FCR_DMA_RST}};
        end else begin
            fifo_en_q <= fifo_en_d;
            dma_q <= dma_d;
        end
    end

    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            dhp_chan_pins #(
                .FIFO_DEPTH(FIFO_DEPTH),
                .CNT_W(CNT_W)
            ) u_pins (
                .i_clock(i_clock),
                .i_rst_n(dev_rst_n),
                .i_fifo_en(fifo_en_q[ch]),
                .i_dma_en(dma_q[ch]),
                .i_auto_rs485(i_auto_rs485[ch]),
                .i_rx_count(i_rx_count[ch]),
                .i_tx_count(i_tx_count[ch]),
                .i_rx_trigger(i_rx_trigger[ch]),
                .i_tx_trigger(i_tx_trigger[ch]),
                .i_rx_timeout(i_rx_timeout[ch]),
                .i_lsr_error(i_lsr_error[ch]),
                .i_tx_shift_empty(i_tx_shift_empty[ch]),
                .o_rx_ready_n(o_rx_ready_n[ch]),
                .o_tx_ready_n(o_tx_ready_n[ch]),
                .o_irq(irq_ch[ch]),
                .o_thr_room(o_lsr_thr_room[ch]),
                .o_tx_empty(o_lsr_tx_empty[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    assign o_data = rdata_q;
    assign o_data_oe = oe_q;
    assign o_reg_addr = addr_q;
    assign o_wr_data = wdata_q;
    assign o_wr_pulse = wr_pulse_q;
    assign o_rd_pulse = rd_pulse_q;
    assign o_chan_reset = chan_rst_q;
    assign o_fifo_enable = fifo_en_q;
    assign o_dma_mode = dma_q;
    assign o_irq_chan_a = irq_ch[0];
    assign o_irq_chan_b = irq_ch[1];
endmodule // dhp_host_port
`default_nettype wire

// ===== core/dhp_pkg.sv
// shared constants and types for the dual uart host port
package dhp_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int NUM_CH = 2;
    localparam int FIFO_DEPTH_DEF = 64;

    // register offset of the fifo control register within a channel
    localparam logic [ADDR_W-1:0] FCR_ADDR = 3'h2;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int FCR_DMA_BIT = 3;
    localparam logic FCR_FIFO_EN_RST = 1'h0;
    localparam logic FCR_DMA_RST = 1'h0;

    // line status bit positions reported or consumed by the pin logic
    localparam int LSR_THR_ROOM_BIT = 5;
    localparam int LSR_TX_EMPTY_BIT = 6;
    localparam int LSR_ERROR_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // reset pulse must be strictly longer than the minimum
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYCLES = RESET_MIN_NS / CLOCK_PERIOD_NS + 1;
    localparam int RST_CNT_W = 3;
    localparam logic [RST_CNT_W-1:0] RST_CNT_TARGET = RST_CNT_W'(RESET_MIN_CYCLES);
    localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 3'h0;
    localparam logic [RST_CNT_W-1:0] RST_CNT_ONE = 3'h1;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic {
        STYLE_SINGLE,
        STYLE_DUAL
    } dhp_style_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } dhp_bus_state_type;

    localparam logic [NUM_CH-1:0] SEL_NONE = 2'h0;
    localparam logic [NUM_CH-1:0] SEL_A = 2'h1;
    localparam logic [NUM_CH-1:0] SEL_B = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 3'h0;
endpackage

// ===== verif/dhp_host_model.sv
// host processor model driving the asynchronous bus pins
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model
    import dhp_pkg::*;
(
    input wire logic i_clock,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic i_data_oe,
    output logic [NUM_CH-1:0] o_sel_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_chan_bit,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_data
);
    initial begin
        o_sel_n = 2'h3;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_chan_bit = 1'b0;
        o_addr = 3'h0;
        o_data = 8'h00;
    end
    ////////////////////////////////////////
    task automatic go(input logic [1:0] s, input logic c, input logic [ADDR_W-1:0] a);
        @(negedge i_clock);
        o_sel_n = s;
        o_chan_bit = c;
        o_addr = a;
    endtask
    // select held past the strobe so the synchronised commit is not aborted
    task automatic stop();
        repeat (4) @(negedge i_clock);
        o_sel_n = 2'h3;
        o_addr = ~o_addr;
        o_data = ~o_data;
        o_chan_bit = ~o_chan_bit;
        repeat (3) @(negedge i_clock);
    endtask
    task automatic wr(input logic [1:0] s, input logic c, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        go(s, c, a);
        o_data = d;
        o_wr_n = 1'b0;
        repeat (4) @(negedge i_clock);
        o_wr_n = 1'b1;
        stop();
    endtask
    task automatic rd(input logic [1:0] s, input logic c, input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        go(s, c, a);
        o_rd_n = 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin
            // sample away from the launching edge
            @(negedge i_clock);
            if (i_data_oe === 1'b1) begin
                ok = 1'b1;
                d = i_data;
            end
        end
        @(negedge i_clock);
        o_rd_n = 1'b1;
        stop();
    endtask
endmodule // dhp_host_model
`default_nettype wire

// ===== verif/dhp_host_port_sva.sv
// concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port_chk
    import dhp_pkg::*;
#(
    parameter int CNT_W = 7
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [NUM_CH-1:0] i_auto_rs485,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_rx_count,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] i_tx_count,
    input wire logic [NUM_CH-1:0] i_tx_shift_empty,
    input wire logic o_data_oe,
    input wire logic [NUM_CH-1:0] o_wr_pulse,
    input wire logic [NUM_CH-1:0] o_rd_pulse,
    input wire logic o_chan_reset,
    input wire logic [NUM_CH-1:0] o_fifo_enable,
    input wire logic [NUM_CH-1:0] o_dma_mode,
    input wire logic [NUM_CH-1:0] o_rx_ready_n,
    input wire logic [NUM_CH-1:0] o_tx_ready_n,
    input wire logic o_irq_chan_a,
    input wire logic [NUM_CH-1:0] o_lsr_tx_empty
);
    default clocking dcb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////
    // pin logic out of both resets for a whole cycle
    sequence s_live;
        $past(i_rst_n) && !o_chan_reset && !$past(o_chan_reset);
    endsequence
    // block mode excluded: there the ready pins keep state
    sequence s_level_a;
        s_live ##0 (!o_dma_mode[0] && !$past(o_dma_mode[0]));
    endsequence
    sequence s_rd_go;
        (o_rd_pulse != 2'h0) ##1 o_data_oe;
    endsequence
    a_wr_pulse_single: assert property (o_wr_pulse != 2'h0 |=> o_wr_pulse == 2'h0)
        else $error("write pulse held past one cycle");
    a_rd_one_chan: assert property ($onehot0(o_rd_pulse))
        else $error("read started on both channels");
    a_rd_drives_bus: assert property (o_rd_pulse != 2'h0 |-> s_rd_go)
        else $error("read start without bus drive");
    a_oe_has_read: assert property ($rose(o_data_oe) |-> $past(o_rd_pulse) != 2'h0)
        else $error("bus driven without a read");
    a_rx_rdy_level: assert property (
        s_level_a |-> o_rx_ready_n[0] == ($past(i_rx_count[0]) == '0))
        else $error("receive ready level wrong");
    a_tx_rdy_level: assert property (
        s_level_a |-> o_tx_ready_n[0] == ($past(i_tx_count[0]) != '0))
        else $error("transmit ready level wrong");
    a_irq_thr_wait: assert property (
        s_level_a ##0 (!o_fifo_enable[0] && !$past(o_fifo_enable[0]) && !$past(i_auto_rs485[0]))
        |-> o_irq_chan_a == ($past(i_tx_count[0]) == '0))
        else $error("interrupt level wrong with fifo off");
    a_tx_empty_flag: assert property (
        s_live |-> o_lsr_tx_empty[1] == ($past(i_tx_count[1]) == '0 && $past(i_tx_shift_empty[1])))
        else $error("transmitter empty flag wrong");
    a_reset_pin_vals: assert property (
        $rose(o_chan_reset) |=> o_rx_ready_n == 2'h3 && o_tx_ready_n == 2'h0 && o_irq_chan_a)
        else $error("pins not at reset values");
endmodule // dhp_host_port_chk
bind dhp_host_port dhp_host_port_chk #(.CNT_W(CNT_W)) i_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_auto_rs485(i_auto_rs485),
    .i_rx_count(i_rx_count), .i_tx_count(i_tx_count), .i_tx_shift_empty(i_tx_shift_empty),
    .o_data_oe(o_data_oe), .o_wr_pulse(o_wr_pulse), .o_rd_pulse(o_rd_pulse),
    .o_chan_reset(o_chan_reset), .o_fifo_enable(o_fifo_enable), .o_dma_mode(o_dma_mode),
    .o_rx_ready_n(o_rx_ready_n), .o_tx_ready_n(o_tx_ready_n), .o_irq_chan_a(o_irq_chan_a),
    .o_lsr_tx_empty(o_lsr_tx_empty));
`default_nettype wire

// ===== verif/tb_top.sv
// testbench for the dual uart host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dhp_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic style = 1'b1;
    logic pin_rst = 1'b0;
    logic [NUM_CH-1:0] sel_n;
    logic rd_n, wr_n, cbit, oe, irq_a, irq_b, chan_rst;
    logic [ADDR_W-1:0] addr, reg_addr;
    logic [DATA_W-1:0] hdata, rdata, wdata;
    logic [NUM_CH-1:0] a485 = 2'h0, tmo = 2'h0, lerr = 2'h0, shemp = 2'h3;
    logic [NUM_CH-1:0] wrp, rdp, fen, dma, rxr, txr, room, temp;
    logic [NUM_CH-1:0] seen_wr = 2'h0, seen_rd = 2'h0;
    logic seen_rst = 1'b0;
    logic clr_seen = 1'b0;
    logic [NUM_CH-1:0][6:0] rxc = '0, txc = '0, rxt = {7'h08, 7'h08}, txt = {7'h08, 7'h08};
    logic [6:0] rx_seq [7] = '{7'h00, 7'h03, 7'h09, 7'h03, 7'h00, 7'h03, 7'h03};
    logic [6:0] tx_seq [7] = '{7'h03, 7'h40, 7'h14, 7'h03, 7'h40, 7'h03, 7'h03};
    int errors = 0;
    int num_checks = 0;
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        seen_wr <= clr_seen ? 2'h0 : (seen_wr | wrp);
        seen_rd <= clr_seen ? 2'h0 : (seen_rd | rdp);
        seen_rst <= !clr_seen && (seen_rst || chan_rst);
    end
    // one driver for the seen flags: the bench only requests a clear
    task automatic clear_seen();
        clr_seen = 1'b1;
        @(negedge i_clock);
        clr_seen = 1'b0;
    endtask
    dhp_host_model i_host (.i_clock(i_clock), .i_data(rdata), .i_data_oe(oe), .o_sel_n(sel_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_chan_bit(cbit), .o_addr(addr), .o_data(hdata));
    dhp_host_port i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_style(style),
        .i_reset_pin(pin_rst), .i_chan_a_select_n(sel_n[0]), .i_chan_b_select_n(sel_n[1]),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_addr(addr),
        .i_channel_addr_bit(cbit), .i_data(hdata), .i_rd_data_a(8'h5A), .i_rd_data_b(8'hC3),
        .i_auto_rs485(a485), .i_rx_count(rxc), .i_tx_count(txc), .i_rx_trigger(rxt),
        .i_tx_trigger(txt), .i_rx_timeout(tmo), .i_lsr_error(lerr), .i_tx_shift_empty(shemp),
        .o_data(rdata), .o_data_oe(oe), .o_reg_addr(reg_addr), .o_wr_data(wdata),
        .o_wr_pulse(wrp), .o_rd_pulse(rdp), .o_chan_reset(chan_rst), .o_fifo_enable(fen),
        .o_dma_mode(dma), .o_rx_ready_n(rxr), .o_tx_ready_n(txr), .o_irq_chan_a(irq_a),
        .o_irq_chan_b(irq_b), .o_lsr_thr_room(room), .o_lsr_tx_empty(temp));
    ////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(negedge i_clock);
    endtask
    // a read that never drives the bus ends the run: later checks would mean nothing
    task automatic rd_chk(input logic [1:0] s, input logic c, input logic [1:0] ch,
                          input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        clear_seen();
        i_host.rd(s, c, 3'h4, d, ok);
        check(d, exp);
        check(8'(reg_addr), 8'h04);
        check(8'(seen_rd), 8'(ch));
        if (ok !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic ok;
        repeat (4) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_clock);
        check(8'({fen, dma}), 8'h00);
        check(8'({rxr, txr}), 8'h0C);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            clear_seen();
            i_host.wr(2'(i), 1'b0, 3'h5, 8'(8'h30 + i));
            check(8'(seen_wr), 8'(~i & 3));
            if (i < 3) check(wdata, 8'(8'h30 + i));
        end
        rd_chk(2'h2, 1'b0, 2'h1, 8'h5A);
        rd_chk(2'h1, 1'b0, 2'h2, 8'hC3);
        i_host.rd(2'h0, 1'b0, 3'h4, d, ok);
        check(8'(ok), 8'h00);
        $display("test dual select done");
        pin_rst = 1'b1; // single style: reset pin idles high
        style = 1'b0;
        repeat (4) @(negedge i_clock);
        for (int i = 0; i < 2; i++) begin
            clear_seen();
            i_host.wr(2'h2, 1'(i), 3'h1, 8'h11);
            check(8'(seen_wr), 8'(1 << i));
        end
        rd_chk(2'h2, 1'b1, 2'h2, 8'hC3);
        $display("test single select done");
        rxc[0] = 7'h01;
        txc[0] = 7'h01;
        settle();
        check(8'({rxr[0], txr[0], irq_a}), 8'h02);
        a485[0] = 1'b1;
        shemp[0] = 1'b0;
        txc[0] = 7'h00;
        settle();
        check(8'(irq_a), 8'h00);
        shemp[0] = 1'b1;
        settle();
        check(8'({irq_a, temp[0]}), 8'h03);
        $display("test fifo off pins done");
        i_host.wr(2'h2, 1'b0, FCR_ADDR, 8'h09);
        i_host.wr(2'h2, 1'b1, FCR_ADDR, 8'h01);
        check(8'({fen, dma}), 8'h0D);
        rxc[1] = 7'h03;
        txc[1] = 7'h05;
        settle();
        check(8'({rxr[1], txr[1], room[1], temp[1], irq_b}), 8'h0C);
        rxc[1] = 7'h14;
        txc[1] = 7'h14;
        settle();
        check(8'(irq_b), 8'h00);
        txc[1] = 7'h03;
        settle();
        check(8'(irq_b), 8'h01);
        txc[1] = 7'h40;
        settle();
        check(8'(room[1]), 8'h00);
        for (int i = 0; i < 7; i++) begin
            rxc[0] = rx_seq[i];
            txc[0] = tx_seq[i];
            tmo[0] = (i == 5);
            lerr[0] = (i == 6);
            settle();
            check(8'({rxr[0], txr[0]}), 8'({1'(7'h53 >> i), 1'(7'h16 >> i)}));
        end
        tmo[0] = 1'b0;
        lerr[0] = 1'b0;
        rxc[0] = 7'h14;
        txc[0] = 7'h14;
        settle();
        check(8'(irq_a), 8'h00);
        txc[0] = 7'h00;
        settle();
        check(8'(irq_a), 8'h01);
        $display("test fifo on pins done");
        clear_seen();
        pin_rst = 1'b0;
        repeat (2) @(negedge i_clock);
        pin_rst = 1'b1;
        repeat (4) @(negedge i_clock);
        check(8'(seen_rst), 8'h00);
        pin_rst = 1'b0;
        repeat (6) @(negedge i_clock);
        pin_rst = 1'b1;
        repeat (6) @(negedge i_clock);
        check(8'({seen_rst, fen}), 8'h04);
        $display("test pin reset done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
